/* File: hdl/ppfs_top.sv */
// Purpose: pin function selection for port 7, the shared port 8 pin and port 13 data
// Assumes: byte register port, read data one cycle after the read strobe
// Notes: pin output enables are active low
//
// Notes on behaviour
// - digital mode plus input: pin reads digitally
// - digital mode plus output: pin drives data
// - analog mode plus input: pin feeds adc
// - analog, input, dac disabled, selected: adc input
// - port 13 bit 0 resets from option byte
//
// register map
// port 7 analog select: bit n high puts pin n in analog mode
// port 7 direction: bit n high makes pin n an input
// port 8 control: bit 0 direction, bit 1 analog, bit 2 dac run, bit 3 dac output enable
// adc channel choice: the shared pin is converted when the channel matches it
// port 8 status: bit 7 synchronised pin level, bits 2:0 decoded role
// port 7 status: bits 4:0 synchronised levels of pins in digital input mode
// port 13 data: bits 4:0 also serve as the port 7 output data
//
// trade-offs
// the option level lands in port 13 bit 0 one cycle after reset; a write then wins
// prohibited settings decode to the safe role: no driver and no converter path
// pin levels pass two flip-flops, so status reads lag the pins by two cycles
`timescale 1ns/1ps
`default_nettype none
module ppfs_top (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // option byte level for port 13 bit 0
  input wire logic port13_bit0_opt_i,
  // register port
  input wire logic [19:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // port 7 pins
  input wire logic [4:0] p7_pin_i,
  output logic [4:0] p7_pin_o,
  output logic [4:0] p7_pin_oe_n_o,
  output logic [4:0] p7_adc_in_en_o,
  // shared port 8 pin
  input wire logic p80_pin_i,
  output logic p80_pin_o,
  output logic p80_pin_oe_n_o,
  output logic p80_dac_out_en_o,
  output logic p80_adc_conv_en_o,
  output logic p80_digital_in_o,
  // port 13 data
  output logic [7:0] port13_data_o
);
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0] adsel_reg;
  logic [7:0] adsel_next;
  logic [7:0] dir_reg;
  logic [7:0] dir_next;
  logic [7:0] p8c_reg;
  logic [7:0] p8c_next;
  logic [7:0] chan_reg;
  logic [7:0] chan_next;
  logic [7:0] p13_reg;
  logic [7:0] p13_next;
  // no port 8 data register exists, so a digital output on the shared pin drives low
  logic [7:0] out7_reg;
  logic [7:0] out7_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic opt_cap_reg;
  logic opt_cap_next;
  logic [4:0] p7_s1_reg;
  logic [4:0] p7_s2_reg;
  logic p80_s1_reg;
  logic p80_s2_reg;
  ppfs_pkg::ppfs_role_t p80_role;
  // synchronised levels of port 7 pins in digital input mode
  logic [4:0] p7_din;

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  always_comb begin
    adsel_next = adsel_reg;
    dir_next = dir_reg;
    p8c_next = p8c_reg;
    chan_next = chan_reg;
    p13_next = p13_reg;
    out7_next = out7_reg;
    // option level is caught in the first clocked cycle after reset release
    opt_cap_next = 1'b1;
    if (!opt_cap_reg) begin
      p13_next[0] = port13_bit0_opt_i;
    end
    if (wr_i) begin
      case (addr_i)
        ppfs_pkg::P7_ADSEL_OFF: adsel_next = wdata_i;
        ppfs_pkg::P7_DIR_OFF: dir_next = wdata_i;
        ppfs_pkg::P8_CTRL_OFF: p8c_next = {4'h0, wdata_i[3:0]};
        ppfs_pkg::ADC_CHAN_OFF: chan_next = wdata_i;
        ppfs_pkg::P13_DATA_OFF: p13_next = wdata_i;
        default: out7_next = out7_reg;
      endcase
    end
  end

  // read data is valid only in the cycle after the strobe
  always_comb begin
    rdata_next = 8'h00;
    if (rd_i) begin
      case (addr_i)
        ppfs_pkg::P7_ADSEL_OFF: rdata_next = adsel_reg;
        ppfs_pkg::P7_DIR_OFF: rdata_next = dir_reg;
        ppfs_pkg::P8_CTRL_OFF: rdata_next = p8c_reg;
        ppfs_pkg::ADC_CHAN_OFF: rdata_next = chan_reg;
        ppfs_pkg::P13_DATA_OFF: rdata_next = p13_reg;
        ppfs_pkg::P80_STAT_OFF: rdata_next = {p80_s2_reg, 4'h0, p80_role};
        ppfs_pkg::P7_STAT_OFF: rdata_next = {3'h0, p7_din};
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      adsel_reg <= ppfs_pkg::P7_ADSEL_RST;
      dir_reg <= ppfs_pkg::P7_DIR_RST;
      p8c_reg <= ppfs_pkg::P8_CTRL_RST;
      chan_reg <= ppfs_pkg::ADC_CHAN_RST;
      p13_reg <= ppfs_pkg::P13_DATA_RST;
      out7_reg <= 8'h00;
      rdata_reg <= 8'h00;
      opt_cap_reg <= 1'b0;
    end else begin
      adsel_reg <= adsel_next;
      dir_reg <= dir_next;
      p8c_reg <= p8c_next;
      chan_reg <= chan_next;
      p13_reg <= p13_next;
      out7_reg <= out7_next;
      rdata_reg <= rdata_next;
      opt_cap_reg <= opt_cap_next;
    end
  end

  // ---------------------------------------------------------------
  // pin input synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      p7_s1_reg <= 5'h00;
      p7_s2_reg <= 5'h00;
      p80_s1_reg <= 1'b0;
      p80_s2_reg <= 1'b0;
    end else begin
      p7_s1_reg <= p7_pin_i;
      p7_s2_reg <= p7_s1_reg;
      p80_s1_reg <= p80_pin_i;
      // only the second stage is read by logic
      p80_s2_reg <= p80_s1_reg;
    end
  end

  // ---------------------------------------------------------------
  // port 7 per-pin function
  // ---------------------------------------------------------------
  // input-first allocation from the top bit is left to software
  for (genvar i = 0; i < ppfs_pkg::P7_PINS; i++) begin : g_p7
    always_comb begin
      p7_pin_o[i] = 1'b0;
      p7_pin_oe_n_o[i] = 1'b1;
      p7_adc_in_en_o[i] = 1'b0;
      p7_din[i] = 1'b0;
      if (!adsel_reg[i] && dir_reg[i]) begin
        p7_din[i] = p7_s2_reg[i];
      end else if (!adsel_reg[i] && !dir_reg[i]) begin
        p7_pin_o[i] = p13_reg[i];
        p7_pin_oe_n_o[i] = 1'b0;
      end else if (adsel_reg[i] && dir_reg[i]) begin
        p7_adc_in_en_o[i] = 1'b1;
      end
      // analog with output direction stays undriven
    end
  end

  // ---------------------------------------------------------------
  // shared port 8 pin
  // ---------------------------------------------------------------
  ppfs_p80_decode u_p80 (
    .analog_sel_i(p8c_reg[ppfs_pkg::P8C_ANALOG_DIGITAL_PORT_CFG_BIT]),
    .dir_in_i(p8c_reg[ppfs_pkg::P8C_DIR_BIT]),
    .dac_run_i(p8c_reg[ppfs_pkg::P8C_DAC_RUN_BIT]),
    .dac_oe_i(p8c_reg[ppfs_pkg::P8C_DAC_OE_BIT]),
    .adc_sel_pin_i(chan_reg == ppfs_pkg::ADC_CHAN_P80),
    .role_o(p80_role)
  );

  always_comb begin
    p80_pin_o = out7_reg[0];
    p80_pin_oe_n_o = (p80_role != ppfs_pkg::PPFS_ROLE_DOUT);
    p80_dac_out_en_o = (p80_role == ppfs_pkg::PPFS_ROLE_DAC_OUT);
    p80_adc_conv_en_o = (p80_role == ppfs_pkg::PPFS_ROLE_AIN_CONV);
    p80_digital_in_o = (p80_role == ppfs_pkg::PPFS_ROLE_DIN) & p80_s2_reg;
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign rdata_o = rdata_reg;
  assign port13_data_o = p13_reg;
endmodule
`default_nettype wire

/* File: hdl/ppfs_pkg.sv */
// Purpose: constants for the port pin function select block
// Assumes: byte-wide register port, one clock
// Notes: offsets are the full addresses of the register space
package ppfs_pkg;
  localparam int ADDR_W = 20;
  // register offsets
  localparam logic [19:0] P7_ADSEL_OFF = 20'hF0067;
  localparam logic [19:0] P13_DATA_OFF = 20'hFFF0D;
  localparam logic [19:0] P7_DIR_OFF = 20'hF0027;
  localparam logic [19:0] P8_CTRL_OFF = 20'hF0028;
  localparam logic [19:0] ADC_CHAN_OFF = 20'hF0029;
  localparam logic [19:0] P80_STAT_OFF = 20'hF002A;
  localparam logic [19:0] P7_STAT_OFF = 20'hF002B;
  // reset values
  localparam logic [7:0] P7_ADSEL_RST = 8'hFF;
  localparam logic [7:0] P7_DIR_RST = 8'hFF;
  localparam logic [7:0] P8_CTRL_RST = 8'h03;
  localparam logic [7:0] ADC_CHAN_RST = 8'h00;
  localparam logic [7:0] P13_DATA_RST = 8'h00;
  // field positions in the port 8 control register
  localparam int P8C_DIR_BIT = 0;
  localparam int P8C_ANALOG_DIGITAL_PORT_CFG_BIT = 1;
  localparam int P8C_DAC_RUN_BIT = 2;
  localparam int P8C_DAC_OE_BIT = 3;
  // adc channel number of the shared pin
  localparam logic [7:0] ADC_CHAN_P80 = 8'h02;
  // number of port 7 pins present
  localparam int P7_PINS = 5;
  // pin role codes
  typedef enum logic [2:0] {
    PPFS_ROLE_SAFE = 3'h0,
    PPFS_ROLE_DIN = 3'h1,
    PPFS_ROLE_DOUT = 3'h2,
    PPFS_ROLE_AIN = 3'h3,
    PPFS_ROLE_AIN_CONV = 3'h4,
    PPFS_ROLE_DAC_OUT = 3'h5
  } ppfs_role_t;
endpackage

/* File: hdl/ppfs_p80_decode.sv */
// Purpose: role decode of the shared digital / adc / dac pin
// Assumes: all inputs come from registers on the same clock, adc_sel_pin_i through a compare
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
module ppfs_p80_decode (
  // settings
  input wire logic analog_sel_i,
  input wire logic dir_in_i,
  input wire logic dac_run_i,
  input wire logic dac_oe_i,
  input wire logic adc_sel_pin_i,
  // decoded role
  output ppfs_pkg::ppfs_role_t role_o
);
  always_comb begin
    role_o = ppfs_pkg::PPFS_ROLE_SAFE;
    if (!analog_sel_i) begin
      // analog output enable in digital mode is refused outright
      if (!dac_oe_i) begin
        role_o = dir_in_i ? ppfs_pkg::PPFS_ROLE_DIN : ppfs_pkg::PPFS_ROLE_DOUT;
      end
    end else if (dir_in_i) begin
      if (dac_oe_i) begin
        if (dac_run_i && !adc_sel_pin_i) begin
          role_o = ppfs_pkg::PPFS_ROLE_DAC_OUT;
        end
      end else if (adc_sel_pin_i) begin
        role_o = ppfs_pkg::PPFS_ROLE_AIN_CONV;
      end else begin
        role_o = ppfs_pkg::PPFS_ROLE_AIN;
      end
    end
    // remaining combinations stay safe and non-driving
  end
endmodule
`default_nettype wire

/* File: dv/ppfs_top_monitor.sv */
// Purpose: port checks for ppfs_top
// Assumes: register shadows follow the write port exactly
// Notes: shadows let pin roles be judged from ports alone
`timescale 1ns/1ps
`default_nettype none
module ppfs_top_monitor (
  input wire logic mclk_i, rst_n_i, port13_bit0_opt_i, wr_i,
  input wire logic [19:0] addr_i,
  input wire logic [7:0] wdata_i, port13_data_o,
  input wire logic [4:0] p7_pin_oe_n_o, p7_adc_in_en_o,
  input wire logic p80_pin_oe_n_o, p80_dac_out_en_o, p80_adc_conv_en_o
);
  logic [7:0] sel_reg, dir_reg, ctl_reg, chan_reg;
  logic an, inp, run, oe, hit;
  assign {oe, run, an, inp} = ctl_reg[3:0];
  assign hit = chan_reg == ppfs_pkg::ADC_CHAN_P80;
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      {sel_reg, dir_reg} <= {ppfs_pkg::P7_ADSEL_RST, ppfs_pkg::P7_DIR_RST};
      {ctl_reg, chan_reg} <= {ppfs_pkg::P8_CTRL_RST, ppfs_pkg::ADC_CHAN_RST};
    end else if (wr_i) begin
      if (addr_i == ppfs_pkg::P7_ADSEL_OFF) sel_reg <= wdata_i;
      if (addr_i == ppfs_pkg::P7_DIR_OFF) dir_reg <= wdata_i;
      if (addr_i == ppfs_pkg::P8_CTRL_OFF) ctl_reg <= wdata_i;
      if (addr_i == ppfs_pkg::ADC_CHAN_OFF) chan_reg <= wdata_i;
    end
  end
  // ----
  // checks
  // ----
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  a_p7_din_role: assert property (
    ((~sel_reg[4:0] & dir_reg[4:0]) & (~p7_pin_oe_n_o | p7_adc_in_en_o)) == 5'h00) else $error("p7 din role");
  a_p7_drive_en: assert property (p7_pin_oe_n_o == (sel_reg[4:0] | dir_reg[4:0])) else $error("p7 oe");
  a_p7_analog_in: assert property (p7_adc_in_en_o == (sel_reg[4:0] & dir_reg[4:0])) else $error("p7 adc");
  a_p80_dac_out: assert property (p80_dac_out_en_o == (an & inp & run & oe & !hit)) else $error("p80 dac");
  a_p80_adc_conv: assert property (p80_adc_conv_en_o == (an & inp & !oe & hit)) else $error("p80 conv");
  a_p80_safe_pin: assert property (
    $onehot0({p80_dac_out_en_o, p80_adc_conv_en_o, !p80_pin_oe_n_o}) && !(an && !p80_pin_oe_n_o))
    else $error("p80 unsafe");
  a_p13_opt_load: assert property ($rose(rst_n_i) && !wr_i |=>
    port13_data_o[0] == $past(port13_bit0_opt_i)) else $error("p13 bit0");
  c_dac: cover property (p80_dac_out_en_o);
  c_conv: cover property (p80_adc_conv_en_o);
  c_p7_mix: cover property (p7_adc_in_en_o != 5'h00 && p7_pin_oe_n_o != 5'h1F);
endmodule
bind ppfs_top ppfs_top_monitor u_mon (.mclk_i, .rst_n_i, .port13_bit0_opt_i, .wr_i, .addr_i, .wdata_i,
  .port13_data_o, .p7_pin_oe_n_o, .p7_adc_in_en_o, .p80_pin_oe_n_o, .p80_dac_out_en_o, .p80_adc_conv_en_o);
`default_nettype wire

/* File: dv/tb.sv */
// Purpose: self-checking bench for ppfs_top
// Assumes: one-cycle strobes, read data in the next cycle
// Notes: pin inputs stay low until the pin input test; roles are read from outputs and status
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct packed {logic [7:0] sel, dir, ctl, chan; logic [4:0] oe, adc; logic [2:0] p80, role;} ppfs_row_t;
  logic mclk_i = 1'h0, rst_n_i = 1'h0, port13_bit0_opt_i = 1'h0, wr_i = 1'h0, rd_i = 1'h0, p80_pin_i = 1'h0;
  logic [19:0] addr_i = 20'h00000;
  logic [7:0] wdata_i = 8'h00, rdata_o, port13_data_o, d;
  logic [4:0] p7_pin_i = 5'h00, p7_pin_o, p7_pin_oe_n_o, p7_adc_in_en_o;
  logic p80_pin_oe_n_o, p80_dac_out_en_o, p80_adc_conv_en_o, p80_pin_o, p80_digital_in_o;
  int errors = 0, compares = 0;
  // p80 field is {dac, conv, oe_n}
  ppfs_row_t rows [10] = '{{8'hFF, 8'hFF, 8'h03, 8'h02, 5'h1F, 5'h1F, 3'h3, 3'h4},
    {8'hE0, 8'hFF, 8'h03, 8'h00, 5'h1F, 5'h00, 3'h1, 3'h3}, {8'hE0, 8'hE0, 8'h0F, 8'h00, 5'h00, 5'h00, 3'h5, 3'h5},
    {8'hFF, 8'hE0, 8'h0F, 8'h02, 5'h1F, 5'h00, 3'h1, 3'h0}, {8'hE5, 8'hFC, 8'h07, 8'h02, 5'h1D, 5'h04, 3'h3, 3'h4},
    {8'hE0, 8'hF8, 8'h0B, 8'h00, 5'h18, 5'h00, 3'h1, 3'h0}, {8'hFF, 8'hFF, 8'h01, 8'h00, 5'h1F, 5'h1F, 3'h1, 3'h1},
    {8'hFF, 8'hFF, 8'h09, 8'h00, 5'h1F, 5'h1F, 3'h1, 3'h0}, {8'hFF, 8'hFF, 8'h02, 8'h00, 5'h1F, 5'h1F, 3'h1, 3'h0},
    {8'hFF, 8'hFF, 8'h00, 8'h00, 5'h1F, 5'h1F, 3'h0, 3'h2}};
  ppfs_top u_dut (.mclk_i, .rst_n_i, .port13_bit0_opt_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .p7_pin_i,
    .p7_pin_o, .p7_pin_oe_n_o, .p7_adc_in_en_o, .p80_pin_i, .p80_pin_o, .p80_pin_oe_n_o, .p80_dac_out_en_o,
    .p80_adc_conv_en_o, .p80_digital_in_o, .port13_data_o);
  initial forever #20 mclk_i = ~mclk_i;
  // ----
  // bus tasks
  // ----
  task wr(input logic [19:0] a, input logic [7:0] v);
    @(posedge mclk_i);
    {addr_i, wdata_i, wr_i} <= {a, v, 1'h1};
    @(posedge mclk_i);
    wr_i <= 1'h0;
  endtask
  task rd(input logic [19:0] a);
    @(posedge mclk_i);
    {addr_i, rd_i} <= {a, 1'h1};
    @(posedge mclk_i);
    rd_i <= 1'h0;
    @(negedge mclk_i);
    d = rdata_o;
  endtask
  task chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      errors++;
      $display("mismatch at %0t got %0h exp %0h", $time, g, e);
    end
  endtask
  task rst(input logic opt);
    @(posedge mclk_i);
    {rst_n_i, port13_bit0_opt_i} <= {1'h0, opt};
    repeat (8) @(posedge mclk_i);
    rst_n_i <= 1'h1;
    @(posedge mclk_i);
    @(negedge mclk_i);
    chk(port13_data_o, {7'h00, opt});
    chk(p7_adc_in_en_o, 5'h1F);
    $display("reset test done");
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge mclk_i);
    errors++;
    give_verdict;
  end
  initial begin
    rst(1'h0);
    foreach (rows[i]) begin
      wr(ppfs_pkg::P7_ADSEL_OFF, rows[i].sel);
      wr(ppfs_pkg::P7_DIR_OFF, rows[i].dir);
      wr(ppfs_pkg::P8_CTRL_OFF, rows[i].ctl);
      wr(ppfs_pkg::ADC_CHAN_OFF, rows[i].chan);
      @(negedge mclk_i);
      chk({p7_pin_oe_n_o, p7_adc_in_en_o}, {rows[i].oe, rows[i].adc});
      chk({p80_dac_out_en_o, p80_adc_conv_en_o, p80_pin_oe_n_o}, rows[i].p80);
      rd(ppfs_pkg::P80_STAT_OFF);
      chk(d & 8'h07, rows[i].role);
      $display("row %0d done", i);
    end
    wr(ppfs_pkg::P7_ADSEL_OFF, 8'h00);
    wr(ppfs_pkg::P7_DIR_OFF, 8'h00);
    wr(ppfs_pkg::P13_DATA_OFF, 8'h5A);
    @(negedge mclk_i);
    chk({p7_pin_o, port13_data_o}, {5'h1A, 8'h5A});
    wr(20'hF0030, 8'hAA);
    rd(20'hF0030);
    chk(d, 8'h00);
    wr(ppfs_pkg::P8_CTRL_OFF, 8'hF3);
    rd(ppfs_pkg::P8_CTRL_OFF);
    chk(d, 8'h03);
    $display("access test done");
    {p7_pin_i, p80_pin_i} <= {5'h15, 1'h1};
    wr(ppfs_pkg::P7_ADSEL_OFF, 8'hE0);
    wr(ppfs_pkg::P7_DIR_OFF, 8'hFF);
    wr(ppfs_pkg::P8_CTRL_OFF, 8'h01);
    @(negedge mclk_i);
    chk({p80_digital_in_o, p80_pin_o}, 2'h2);
    rd(ppfs_pkg::P7_STAT_OFF);
    chk(d, 8'h15);
    rd(ppfs_pkg::P80_STAT_OFF);
    chk(d, 8'h81);
    $display("pin input test done");
    rst(1'h1);
    rd(ppfs_pkg::P7_ADSEL_OFF);
    chk(d, ppfs_pkg::P7_ADSEL_RST);
    give_verdict;
  end
endmodule
`default_nettype wire
